// ===== include/see_pkg.sv
package see_pkg;
   // ****************************************************
   // Geometry.
   // ****************************************************
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int PAGE_W = 3;
   localparam int DEPTH = 128;
   localparam logic [7:0] ERASED = 8'hFF;
   // ****************************************************
   // Select byte layout.
   // ****************************************************
   // Device type code; the value is arbitrary.
   localparam logic [3:0] TYPE_ID = 4'h6;
   localparam int TYPE_HI = 7;
   localparam int TYPE_LO = 4;
   localparam int DIR_BIT = 0;
   localparam logic DIR_READ = 1'b1;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // ****************************************************
   // Timing.
   // ****************************************************
   localparam int CLK_MHZ = 100;
   localparam int PROG_MS = 10;
   localparam int PROG_CYC = PROG_MS * 1000 * CLK_MHZ;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_SEL = 5'b0_0010,
      ST_ADDR = 5'b0_0100,
      ST_WDATA = 5'b0_1000,
      ST_RDATA = 5'b1_0000
   } see_state_t;
endpackage

// ===== sim/see_eeprom_assertions.sv
`timescale 1ns/1ns
module see_chk #(
   parameter int PROG_CYCLES = 200
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Pins.
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic transmit_only_clock_write_enable,
   input wire logic busy
);
   localparam int PLIM = PROG_CYCLES + 8;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_prog;
      $rose(busy) ##1 busy[*7];
   endsequence
   a_prog_min: assert property ($rose(busy) |-> s_prog)
      else $error("program pulse short");
   a_prog_end: assert property ($rose(busy) |-> ##[1:PLIM] !busy)
      else $error("program cycle too long");
   a_prog_stop: assert property ($rose(busy) |-> scl && sda_in)
      else $error("program without stop");
   a_busy_quiet: assert property (busy |-> !sda_oe)
      else $error("drive while busy");
   a_drive_low: assert property (sda_oe |-> !sda_out)
      else $error("data pin driven high");
   a_oe_fall: assert property ($changed(sda_oe) |-> !scl && !$past(scl, 2))
      else $error("data moved before clock low");
   a_oe_steady: assert property (scl && $past(scl) |-> $stable(sda_oe))
      else $error("data moved while clock high");
   a_wen_gate: assert property ($rose(busy) |-> $past(transmit_only_clock_write_enable, 16))
      else $error("program with write disabled");
endmodule
bind see_eeprom see_chk #(.PROG_CYCLES(PROG_CYCLES)) see_chk_i (.mclk(mclk), .nrst(nrst),
   .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
   .transmit_only_clock_write_enable(transmit_only_clock_write_enable));

// ===== sim/see_master.sv
`timescale 1ns/1ns
module see_master (
   // Clock.
   input wire logic mclk,
   // Bus.
   input wire logic sda,
   output logic scl,
   output logic m_oe
);
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task automatic w(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic bit_x(logic b, output logic r);
      m_oe = !b;
      w(4);
      scl = 1'b1;
      w(4);
      r = sda;
      w(4);
      scl = 1'b0;
      w(4);
   endtask
   task automatic start;
      m_oe = 1'b0;
      w(4);
      scl = 1'b1;
      w(8);
      m_oe = 1'b1;
      w(8);
      scl = 1'b0;
      w(4);
   endtask
   task automatic stop;
      m_oe = 1'b1;
      w(4);
      scl = 1'b1;
      w(8);
      m_oe = 1'b0;
      w(8);
   endtask
   task automatic put(logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(v[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic get(logic nak, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
      bit_x(nak, r);
   endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
   import see_pkg::*;
   localparam logic [7:0] SEL_WR = {TYPE_ID, 4'h0};
   localparam logic [7:0] SEL_RD = {TYPE_ID, 4'h1};
   localparam logic [7:0] SEL_FOREIGN = {~TYPE_ID, 4'h1};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic we = 1'b1;
   wire scl, m_oe, sda_out, sda_oe, busy;
   wire sda = !(m_oe || sda_oe);
   int miscompares = 0;
   int checks_done = 0;
   always #5 mclk = ~mclk;
   see_eeprom #(.PROG_CYCLES(200)) see_eeprom_i (.mclk(mclk), .nrst(nrst), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
      .transmit_only_clock_write_enable(we));
   see_master see_master_i (.mclk(mclk), .sda(sda), .scl(scl), .m_oe(m_oe));
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tx(logic [7:0] v, logic e, string n);
      logic a;
      see_master_i.put(v, a);
      chk(n, 8'(e), 8'(a));
   endtask
   task automatic rd(logic [7:0] ad);
      see_master_i.start();
      tx(SEL_WR, 1'b1, "sel wr");
      tx(ad, 1'b1, "addr");
      see_master_i.start();
      tx(SEL_RD, 1'b1, "sel rd");
   endtask
   task automatic t_blank;
      logic [7:0] d;
      see_master_i.start();
      tx(SEL_RD, 1'b1, "cur sel");
      see_master_i.get(1'b1, d);
      chk("blank", 8'hFF, d);
      see_master_i.stop();
      see_master_i.start();
      tx(SEL_FOREIGN, 1'b0, "foreign");
      see_master_i.stop();
   endtask
   task automatic t_page;
      logic a;
      logic [7:0] d;
      a = 1'b0;
      rd(8'h7E);
      see_master_i.start();
      tx(SEL_WR, 1'b1, "sel wr");
      tx(8'h7E, 1'b1, "addr");
      for (int k = 0; k < 8; k++) tx(8'(8'h10 + k), 1'b1, "page");
      see_master_i.stop();
      chk("busy", 8'h01, 8'(busy));
      see_master_i.start();
      tx(SEL_WR, 1'b0, "poll busy");
      repeat (8) if (!a) begin
         see_master_i.start();
         see_master_i.put(SEL_WR, a);
      end
      chk("poll", 8'h01, 8'(a));
      tx(8'h7A, 1'b1, "addr");
      see_master_i.start();
      tx(SEL_RD, 1'b1, "sel rd");
      see_master_i.get(1'b1, d);
      chk("rand", 8'h14, d);
      see_master_i.w(4);
      chk("release", 8'h01, 8'(sda));
      see_master_i.stop();
   endtask
   task automatic t_seq;
      logic [7:0] d;
      rd(8'h78);
      for (int j = 0; j < 9; j++) begin
         see_master_i.get(j == 8, d);
         chk("seq", j < 8 ? 8'(8'h10 + ((j + 2) % 8)) : 8'hFF, d);
      end
      see_master_i.stop();
   endtask
   task automatic t_wen;
      logic [7:0] d;
      we = 1'b0;
      rd(8'h7B);
      see_master_i.get(1'b1, d);
      chk("wp before", 8'h15, d);
      see_master_i.stop();
      see_master_i.start();
      tx(SEL_WR, 1'b1, "sel wr");
      tx(8'h7B, 1'b1, "addr");
      tx(8'h00, 1'b1, "wp ack");
      see_master_i.stop();
      chk("wp busy", 8'h00, 8'(busy));
      we = 1'b1;
      rd(8'h7B);
      see_master_i.get(1'b1, d);
      chk("wp keep", 8'h15, d);
      see_master_i.stop();
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1;
      nrst = 1'b1;
      see_master_i.w(4);
      t_blank();
      t_page();
      t_seq();
      t_wen();
      end_sim();
   end
   initial begin
      #500000;
      miscompares++;
      end_sim();
   end
endmodule

// ===== verilog/see_eeprom.sv
`timescale 1ns/1ns
module see_eeprom #(
   parameter int PROG_CYCLES = see_pkg::PROG_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Serial bus.
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Write enable.
   input wire logic transmit_only_clock_write_enable,
   // Status.
   output logic busy
);
   import see_pkg::*;

   // ****************************************************
   // Input synchronisers.
   // ****************************************************
   logic scl_s;
   logic sda_s;
   logic we_s;
   see_sync u_scl (.mclk(mclk), .nrst(nrst), .din(scl), .dout(scl_s));
   see_sync u_sda (.mclk(mclk), .nrst(nrst), .din(sda_in), .dout(sda_s));
   see_sync u_we (.mclk(mclk), .nrst(nrst),
      .din(transmit_only_clock_write_enable), .dout(we_s));

   logic scl_d;
   logic sda_d;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   assign rise = scl_s && !scl_d;
   assign fall = !scl_s && scl_d;
   assign start_c = scl_s && scl_d && sda_d && !sda_s;
   assign stop_c = scl_s && scl_d && !sda_d && sda_s;

   // ****************************************************
   // Array and page latches.
   // ****************************************************
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] page [1 << PAGE_W];
   logic [(1 << PAGE_W)-1:0] pmask;
   logic [ADDR_W-1:0] prow;

   // ****************************************************
   // Protocol state.
   // ****************************************************
   see_state_t state;
   see_state_t next_state;
   logic [3:0] bitn;
   logic [3:0] next_bitn;
   logic [DATA_W-1:0] sh;
   logic [DATA_W-1:0] next_sh;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] next_addr;
   logic ack_ok;
   logic next_ack_ok;
   logic next_sda_out;
   logic next_sda_oe;
   logic [31:0] pcnt;
   logic [31:0] next_pcnt;
   logic next_busy;
   logic pend;
   logic next_pend;
   logic wr_pg;
   logic commit;
   logic [DATA_W-1:0] rbyte;
   assign rbyte = mem[addr];

   always_comb begin
      next_state = state;
      next_bitn = bitn;
      next_sh = sh;
      next_addr = addr;
      next_ack_ok = ack_ok;
      next_sda_out = sda_out;
      next_sda_oe = sda_oe;
      next_pcnt = pcnt;
      next_busy = busy;
      next_pend = pend;
      wr_pg = 1'b0;
      commit = 1'b0;
      if (busy) begin
         next_sda_oe = 1'b0;
         next_state = ST_IDLE;
         if (pcnt == 32'(PROG_CYCLES - 1)) begin
            next_busy = 1'b0;
            next_pcnt = '0;
         end else begin
            next_pcnt = pcnt + 32'd1;
         end
      end else if (stop_c) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
         if (pend) begin
            commit = 1'b1;
            next_pend = 1'b0;
            next_busy = 1'b1;
            next_pcnt = '0;
         end
      end else if (start_c) begin
         next_state = ST_SEL;
         // The clock fall that closes a START wraps the count to zero.
         next_bitn = '1;
         next_sda_oe = 1'b0;
         next_pend = 1'b0;
      end else if (state != ST_IDLE) begin
         if (rise) begin
            if (bitn == BIT_ACK) begin
               if (state == ST_RDATA && sda_s) begin
                  next_state = ST_IDLE;
               end
            end else if (state != ST_RDATA) begin
               next_sh = {sh[DATA_W-2:0], sda_s};
            end
         end
         if (fall) begin
            next_bitn = bitn + 4'd1;
            next_sda_oe = 1'b0;
            if (bitn == BIT_LAST && state != ST_RDATA) begin
               next_ack_ok = 1'b1;
               unique case (state)
                  ST_SEL: begin
                     next_ack_ok = sh[TYPE_HI:TYPE_LO] == TYPE_ID;
                  end
                  ST_ADDR: begin
                     next_addr = sh[ADDR_W-1:0];
                  end
                  ST_WDATA: begin
                     wr_pg = we_s;
                     next_pend = we_s;
                  end
                  default: begin
                  end
               endcase
               next_sda_out = 1'b0;
               next_sda_oe = next_ack_ok;
               if (!next_ack_ok) begin
                  next_state = ST_IDLE;
               end
            end else if (bitn == BIT_ACK) begin
               next_bitn = '0;
               unique case (state)
                  ST_SEL: begin
                     next_state = (sh[DIR_BIT] == DIR_READ) ? ST_RDATA : ST_ADDR;
                  end
                  ST_ADDR: next_state = ST_WDATA;
                  ST_WDATA: begin
                     next_addr = {addr[ADDR_W-1:PAGE_W], addr[PAGE_W-1:0] + 3'd1};
                  end
                  default: begin
                  end
               endcase
               if (next_state == ST_RDATA) begin
                  next_sh = rbyte;
                  next_sda_out = rbyte[DATA_W-1];
                  next_sda_oe = !rbyte[DATA_W-1];
                  next_addr = addr + 7'd1;
               end
            end else if (state == ST_RDATA) begin
               if (bitn == BIT_LAST) begin
                  next_sda_oe = 1'b0;
               end else begin
                  next_sh = {sh[DATA_W-2:0], 1'b1};
                  next_sda_out = sh[DATA_W-2];
                  next_sda_oe = !sh[DATA_W-2];
               end
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= ST_IDLE;
         bitn <= '0;
         sh <= '0;
         addr <= '0;
         ack_ok <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         pcnt <= '0;
         busy <= 1'b0;
         pend <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         state <= next_state;
         bitn <= next_bitn;
         sh <= next_sh;
         addr <= next_addr;
         ack_ok <= next_ack_ok;
         sda_out <= next_sda_out;
         sda_oe <= next_sda_oe;
         pcnt <= next_pcnt;
         busy <= next_busy;
         pend <= next_pend;
      end
   end

   // ****************************************************
   // Page latches and array programming.
   // ****************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pmask <= '0;
         prow <= '0;
      end else if (start_c) begin
         pmask <= '0;
      end else if (wr_pg) begin
         pmask[addr[PAGE_W-1:0]] <= 1'b1;
         prow <= addr;
      end else if (commit) begin
         pmask <= '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_pg) begin
         page[addr[PAGE_W-1:0]] <= sh;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= ERASED;
         end
      end else if (commit) begin
         for (int j = 0; j < (1 << PAGE_W); j++) begin
            if (pmask[j]) begin
               mem[{prow[ADDR_W-1:PAGE_W], 3'(j)}] <= page[j];
            end
         end
      end
   end
endmodule

// ===== verilog/see_sync.sv
`timescale 1ns/1ns
module see_sync (
   // Clock and reset.
   input wire logic mclk,
   input wire logic nrst,
   // Signal.
   input wire logic din,
   output logic dout
);
   logic meta;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b1;
         dout <= 1'b1;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
